// *** hsfm_defines.vh ***
`ifndef HSFM_DEFINES_VH
`define HSFM_DEFINES_VH

// Channel count: first lamp driver plus five shared-setting drivers
`define HSFM_NCH 6
// Index of the fifth driver inside the channel vector
`define HSFM_FIFTH_IDX 4
// Clock rate
`define HSFM_CLK_MHZ 100
// Times in microseconds
`define HSFM_BLANK_US 40
`define HSFM_DG_48_US 48
`define HSFM_DG_40_US 40
`define HSFM_DG_32_US 32
`define HSFM_DG_24_US 24
`define HSFM_DG_HV_US 10
`define HSFM_OL_TEST_US 200
// Off timeout in milliseconds
`define HSFM_OL_OFF_MS 10
// Cycle counts derived from the times
`define HSFM_BLANK_CYC (`HSFM_BLANK_US * `HSFM_CLK_MHZ)
`define HSFM_DG_48_CYC (`HSFM_DG_48_US * `HSFM_CLK_MHZ)
`define HSFM_DG_40_CYC (`HSFM_DG_40_US * `HSFM_CLK_MHZ)
`define HSFM_DG_32_CYC (`HSFM_DG_32_US * `HSFM_CLK_MHZ)
`define HSFM_DG_24_CYC (`HSFM_DG_24_US * `HSFM_CLK_MHZ)
`define HSFM_DG_HV_CYC (`HSFM_DG_HV_US * `HSFM_CLK_MHZ)
`define HSFM_OL_TEST_CYC (`HSFM_OL_TEST_US * `HSFM_CLK_MHZ)
`define HSFM_OL_OFF_CYC (`HSFM_OL_OFF_MS * 1000 * `HSFM_CLK_MHZ)
// Deglitch field codes
`define HSFM_DGSEL_48 2'h0
`define HSFM_DGSEL_40 2'h1
`define HSFM_DGSEL_32 2'h2
`define HSFM_DGSEL_24 2'h3
// Reset value of the glass supply mode bit
`define HSFM_GLASS_MODE_RST 1'b1
// Timer width
`define HSFM_TW 17

`endif

// *** hsfm_channel.v ***
`timescale 1ns/1ps
`include "hsfm_defines.vh"

module hsfm_channel (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Control
    input wire drvOn,
    input wire clearFaults,
    input wire retryEnable,
    input wire [`HSFM_TW-1:0] dgCycles,
    // Synchronized comparators
    input wire shortCmp,
    input wire overCmp,
    // Results
    output reg shortFlag_r,
    output reg tripFlag_r,
    output reg faultOff_r,
    output reg retryOff_r
);

    reg [`HSFM_TW-1:0] blankCnt_r;
    reg [`HSFM_TW-1:0] scCnt_r;
    reg [`HSFM_TW-1:0] ocCnt_r;
    reg drvOnD_r;
    wire active;
    wire rise;
    wire scHit;
    wire ocHit;

    assign rise = drvOn && !drvOnD_r;
    assign active = drvOn && !faultOff_r && !retryOff_r && (blankCnt_r == `HSFM_BLANK_CYC);
    assign scHit = active && shortCmp && (scCnt_r + 1'b1 >= dgCycles);
    assign ocHit = active && overCmp && (ocCnt_r + 1'b1 >= dgCycles);

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            blankCnt_r <= {`HSFM_TW{1'b0}};
            scCnt_r <= {`HSFM_TW{1'b0}};
            ocCnt_r <= {`HSFM_TW{1'b0}};
            drvOnD_r <= 1'b0;
            shortFlag_r <= 1'b0;
            tripFlag_r <= 1'b0;
            faultOff_r <= 1'b0;
            retryOff_r <= 1'b0;
        end else begin
            drvOnD_r <= drvOn;
            // Blank restarts at every enable
            if (!drvOn || rise || retryOff_r) begin
                blankCnt_r <= {`HSFM_TW{1'b0}};
            end else if (blankCnt_r != `HSFM_BLANK_CYC) begin
                blankCnt_r <= blankCnt_r + 1'b1;
            end
            if (active && shortCmp) begin
                scCnt_r <= scCnt_r + 1'b1;
            end else begin
                scCnt_r <= {`HSFM_TW{1'b0}};
            end
            if (active && overCmp) begin
                ocCnt_r <= ocCnt_r + 1'b1;
            end else begin
                ocCnt_r <= {`HSFM_TW{1'b0}};
            end
            // Retry mode: a short off pulse only, no latched flag
            retryOff_r <= ocHit && retryEnable;
            // Set wins over clear
            if (scHit) begin
                shortFlag_r <= 1'b1;
            end else if (clearFaults) begin
                shortFlag_r <= 1'b0;
            end
            if (ocHit && !retryEnable) begin
                tripFlag_r <= 1'b1;
            end else if (clearFaults) begin
                tripFlag_r <= 1'b0;
            end
            // Shut-off holds until the driver is commanded off again
            if (scHit || (ocHit && !retryEnable)) begin
                faultOff_r <= 1'b1;
            end else if (!drvOn) begin
                faultOff_r <= 1'b0;
            end
        end
    end

endmodule

// *** hsfm_monitor.v ***
`timescale 1ns/1ps
`include "hsfm_defines.vh"

// Notes on behaviour
// - 2V short comparator after blank turns output off
// - Short and overcurrent comparators ignored 40us from each enable
// - First driver own deglitch; above 20V 10us
// - Deglitch codes 00=48,01=40,10=32,11=24us
// - Short latches flag until clear, output off until command off
// - Overcurrent shutdown only when retry disabled
// - Overcurrent level from mode bit or select
// - Overcurrent blanked 40us then deglitched
// - Overcurrent latches trip flag, output off
// - Open-load level per driver; first from mode
// - Open load sets flag, driver stays on
// - Sequence enabled drivers, 200us each, restart
// - Flagged drivers skipped until clear faults
// - Short on-phase waits; off over 10ms ends
// - Glass mode ignores fifth driver own command and retry
// - Mode cleared: fifth driver independent
// - No retry regulation on the fifth driver in glass mode
module hsfm_monitor (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Driver commands, bit 0 first lamp driver
    input wire [5:0] driverOnCmd,
    input wire glassSupplyOn,
    input wire glassSupplyModeWr,
    input wire glassSupplyModeVal,
    input wire clearFaults,
    // Configuration
    input wire [1:0] firstDriverDeglitchSel,
    input wire [1:0] sharedDriverDeglitchSel,
    input wire firstDriverRetryEnable,
    input wire [4:0] driverRetryEnable,
    input wire firstDriverResistanceMode,
    input wire [4:0] driverOvercurrentLevelSel,
    input wire [4:0] driverOpenLoadLevelSel,
    input wire [5:0] driverOpenLoadEnable,
    // Analog comparators from pins
    input wire [5:0] shortCmpPin,
    input wire [5:0] overCmpHiPin,
    input wire [5:0] overCmpLoPin,
    input wire [5:0] openCmpHiPin,
    input wire [5:0] openCmpLoPin,
    input wire supplyAbove20vPin,
    // Outputs
    output reg [5:0] driverEnable_r,
    output reg [5:0] overcurrentLevel_r,
    output reg [5:0] openLoadLevel_r,
    output reg glassSupplyMode_r,
    output reg [5:0] outputShortFlag_r,
    output reg [5:0] driverTripFlag_r,
    output reg [5:0] driverOpenLoadFlag_r
);

    localparam ST_SEEK = 2'h0;
    localparam ST_TEST = 2'h1;

    reg [5:0] shortS1_r, shortS2_r;
    reg [5:0] ocHiS1_r, ocHiS2_r, ocLoS1_r, ocLoS2_r;
    reg [5:0] olHiS1_r, olHiS2_r, olLoS1_r, olLoS2_r;
    reg hvS1_r, hvS2_r;
    reg [1:0] state_r;
    reg [2:0] olIdx_r;
    reg [`HSFM_TW-1:0] olOnCnt_r;
    reg [20:0] olOffCnt_r;
    reg olLow_r;
    reg [5:0] drvOn;
    reg [5:0] retryEn;
    wire [5:0] shortFlag, tripFlag, faultOff, retryOff;
    wire [5:0] ocCmp, olCmp;
    reg [`HSFM_TW-1:0] dgFirst, dgShared;

    function [`HSFM_TW-1:0] dgDecode;
        input [1:0] sel;
        input hv;
        reg [31:0] cyc;
        begin
            if (hv) begin
                cyc = `HSFM_DG_HV_CYC;
            end else begin
                case (sel)
                    `HSFM_DGSEL_48: cyc = `HSFM_DG_48_CYC;
                    `HSFM_DGSEL_40: cyc = `HSFM_DG_40_CYC;
                    `HSFM_DGSEL_32: cyc = `HSFM_DG_32_CYC;
                    default: cyc = `HSFM_DG_24_CYC;
                endcase
            end
            dgDecode = cyc[`HSFM_TW-1:0];
        end
    endfunction

    // Two-stage synchronizers for all analog inputs
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            shortS1_r <= 6'h00;
            shortS2_r <= 6'h00;
            ocHiS1_r <= 6'h00;
            ocHiS2_r <= 6'h00;
            ocLoS1_r <= 6'h00;
            ocLoS2_r <= 6'h00;
            olHiS1_r <= 6'h00;
            olHiS2_r <= 6'h00;
            olLoS1_r <= 6'h00;
            olLoS2_r <= 6'h00;
            hvS1_r <= 1'b0;
            hvS2_r <= 1'b0;
        end else begin
            shortS1_r <= shortCmpPin;
            shortS2_r <= shortS1_r;
            ocHiS1_r <= overCmpHiPin;
            ocHiS2_r <= ocHiS1_r;
            ocLoS1_r <= overCmpLoPin;
            ocLoS2_r <= ocLoS1_r;
            olHiS1_r <= openCmpHiPin;
            olHiS2_r <= olHiS1_r;
            olLoS1_r <= openCmpLoPin;
            olLoS2_r <= olLoS1_r;
            hvS1_r <= supplyAbove20vPin;
            hvS2_r <= hvS1_r;
        end
    end

    always @* begin
        dgFirst = dgDecode(firstDriverDeglitchSel, hvS2_r);
        dgShared = dgDecode(sharedDriverDeglitchSel, hvS2_r);
        drvOn = driverOnCmd;
        retryEn = {driverRetryEnable, firstDriverRetryEnable};
        if (glassSupplyMode_r) begin
            drvOn[`HSFM_FIFTH_IDX] = glassSupplyOn;
            retryEn[`HSFM_FIFTH_IDX] = 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `HSFM_NCH; g = g + 1) begin : gCh
            assign ocCmp[g] = overcurrentLevel_r[g] ? ocHiS2_r[g] : ocLoS2_r[g];
            assign olCmp[g] = openLoadLevel_r[g] ? olHiS2_r[g] : olLoS2_r[g];
            hsfm_channel uCh (
                .clk(clk),
                .reset(reset),
                .drvOn(drvOn[g]),
                .clearFaults(clearFaults),
                .retryEnable(retryEn[g]),
                .dgCycles(g == 0 ? dgFirst : dgShared),
                .shortCmp(shortS2_r[g]),
                .overCmp(ocCmp[g]),
                .shortFlag_r(shortFlag[g]),
                .tripFlag_r(tripFlag[g]),
                .faultOff_r(faultOff[g]),
                .retryOff_r(retryOff[g])
            );
        end
    endgenerate

    // Mode bit, enables and level selects
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            glassSupplyMode_r <= `HSFM_GLASS_MODE_RST;
            driverEnable_r <= 6'h00;
            overcurrentLevel_r <= 6'h00;
            openLoadLevel_r <= 6'h00;
            outputShortFlag_r <= 6'h00;
            driverTripFlag_r <= 6'h00;
        end else begin
            if (glassSupplyModeWr) begin
                glassSupplyMode_r <= glassSupplyModeVal;
            end
            driverEnable_r <= drvOn & ~faultOff & ~retryOff;
            overcurrentLevel_r <= {driverOvercurrentLevelSel, firstDriverResistanceMode};
            openLoadLevel_r <= {driverOpenLoadLevelSel, firstDriverResistanceMode};
            outputShortFlag_r <= shortFlag;
            driverTripFlag_r <= tripFlag;
        end
    end

    // Open-load sequencer
    wire [5:0] olCand;
    wire curOn;
    assign olCand = driverOpenLoadEnable & ~driverOpenLoadFlag_r;
    assign curOn = driverEnable_r[olIdx_r];

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_SEEK;
            olIdx_r <= 3'h0;
            olOnCnt_r <= {`HSFM_TW{1'b0}};
            olOffCnt_r <= 21'h000000;
            olLow_r <= 1'b1;
            driverOpenLoadFlag_r <= 6'h00;
        end else begin
            if (clearFaults) begin
                driverOpenLoadFlag_r <= 6'h00;
            end
            case (state_r)
                ST_SEEK: begin
                    olOnCnt_r <= {`HSFM_TW{1'b0}};
                    olOffCnt_r <= 21'h000000;
                    olLow_r <= 1'b1;
                    if (olCand[olIdx_r]) begin
                        state_r <= ST_TEST;
                    end else begin
                        olIdx_r <= (olIdx_r == 3'h5) ? 3'h0 : olIdx_r + 3'h1;
                    end
                end
                ST_TEST: begin
                    if (!olCand[olIdx_r]) begin
                        state_r <= ST_SEEK;
                    end else if (curOn) begin
                        olOffCnt_r <= 21'h000000;
                        olLow_r <= olLow_r & olCmp[olIdx_r];
                        if (olOnCnt_r == `HSFM_OL_TEST_CYC - 1) begin
                            if (olLow_r && olCmp[olIdx_r]) begin
                                driverOpenLoadFlag_r[olIdx_r] <= 1'b1;
                            end
                            state_r <= ST_SEEK;
                            olIdx_r <= (olIdx_r == 3'h5) ? 3'h0 : olIdx_r + 3'h1;
                        end else begin
                            olOnCnt_r <= olOnCnt_r + 1'b1;
                        end
                    end else begin
                        // Short on-phase: restart on next on-phase
                        olOnCnt_r <= {`HSFM_TW{1'b0}};
                        olLow_r <= 1'b1;
                        if (olOffCnt_r == `HSFM_OL_OFF_CYC) begin
                            state_r <= ST_SEEK;
                            olIdx_r <= (olIdx_r == 3'h5) ? 3'h0 : olIdx_r + 3'h1;
                        end else begin
                            olOffCnt_r <= olOffCnt_r + 1'b1;
                        end
                    end
                end
                default: begin
                    state_r <= ST_SEEK;
                end
            endcase
        end
    end

endmodule

// *** hsfm_monitor_properties.sv ***
`timescale 1ns/1ps
module hsfm_monitor_checker (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Commands and configuration
    input wire [5:0] driverOnCmd,
    input wire glassSupplyOn,
    input wire clearFaults,
    input wire firstDriverRetryEnable,
    input wire [4:0] driverRetryEnable,
    input wire firstDriverResistanceMode,
    input wire [4:0] driverOvercurrentLevelSel,
    // Results
    input wire [5:0] driverEnable_r,
    input wire [5:0] overcurrentLevel_r,
    input wire glassSupplyMode_r,
    input wire [5:0] outputShortFlag_r,
    input wire [5:0] driverTripFlag_r,
    input wire [5:0] driverOpenLoadFlag_r
);
    wire [17:0] allFlags = {outputShortFlag_r, driverTripFlag_r, driverOpenLoadFlag_r};
    wire [5:0] ocCfg = {driverOvercurrentLevelSel, firstDriverResistanceMode};
    // Enabled time of drivers 0 and 1
    reg [15:0] onCnt0_r;
    reg [15:0] onCnt1_r;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            onCnt0_r <= 16'h0000;
            onCnt1_r <= 16'h0000;
        end else begin
            onCnt0_r <= driverEnable_r[0] ? onCnt0_r + 16'h0001 : 16'h0000;
            onCnt1_r <= driverEnable_r[1] ? onCnt1_r + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_short_turns_off: assert property (((outputShortFlag_r & ~$past(outputShortFlag_r)) & driverEnable_r) == 6'h00)
        else $error("short flag on running output");
    a_flags_sticky: assert property ($past(clearFaults) || $past(clearFaults, 2) || ($past(allFlags) & ~allFlags) == 18'h00000)
        else $error("flag dropped without clear");
    a_clear_empties: assert property ((driverEnable_r == 6'h00)[*3] ##0 clearFaults |-> ##2 allFlags == 18'h00000)
        else $error("clear left a flag");
    a_short_blank: assert property ($rose(outputShortFlag_r[1]) |-> $past(onCnt1_r, 2) >= 16'h137E)
        else $error("short detected too early");
    a_trip_blank: assert property ($rose(driverTripFlag_r[0]) |-> $past(onCnt0_r, 2) >= 16'h137E)
        else $error("trip detected too early");
    a_oc_level: assert property ($stable(ocCfg) && !$past(reset) |-> overcurrentLevel_r == ocCfg)
        else $error("overcurrent level wrong");
    a_glass_ignores: assert property (glassSupplyMode_r && !glassSupplyOn |=> !driverEnable_r[4])
        else $error("fifth driver on in glass mode");
    a_retry_no_trip: assert property ((((driverTripFlag_r & ~$past(driverTripFlag_r))
        & $past({driverRetryEnable, firstDriverRetryEnable}, 2)) & {1'b1, ~glassSupplyMode_r, 4'hF}) == 6'h00)
        else $error("trip flag with retry enabled");
    a_open_stays_on: assert property ((((driverOpenLoadFlag_r & ~$past(driverOpenLoadFlag_r))
        & driverOnCmd & $past(driverOnCmd) & ~driverEnable_r) & 6'h2F) == 6'h00)
        else $error("open load switched driver off");
endmodule

bind hsfm_monitor hsfm_monitor_checker hsfm_monitor_checker_inst (.*);

// *** hsfm_far_side.sv ***
`timescale 1ns/1ps
module hsfm_far_side (
    // Clock
    input wire clk,
    // Driver state and injected load conditions
    input wire [5:0] driverEnable_r,
    input wire [5:0] shortFault,
    input wire [5:0] overFault,
    input wire [5:0] openFault,
    input wire hvSupply,
    // Comparator results
    output reg [5:0] shortCmpPin,
    output reg [5:0] overCmpHiPin,
    output reg [5:0] overCmpLoPin,
    output reg [5:0] openCmpHiPin,
    output reg [5:0] openCmpLoPin,
    output reg supplyAbove20vPin
);
    // Short and overcurrent show only while the output conducts; open-load compares also read high while it is off
    always @(posedge clk) begin
        shortCmpPin <= driverEnable_r & shortFault;
        {overCmpHiPin, overCmpLoPin} <= {2{driverEnable_r & overFault}};
        {openCmpHiPin, openCmpLoPin} <= {2{~driverEnable_r | openFault}};
        supplyAbove20vPin <= hvSupply;
    end
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
`include "hsfm_defines.vh"
module tb;
    reg clk;
    reg reset;
    reg [5:0] driverOnCmd, driverOpenLoadEnable, shortFault, overFault, openFault;
    reg glassSupplyOn, glassSupplyModeWr, glassSupplyModeVal, clearFaults, hvSupply;
    reg [1:0] firstDriverDeglitchSel, sharedDriverDeglitchSel;
    reg firstDriverRetryEnable, firstDriverResistanceMode;
    reg [4:0] driverRetryEnable, driverOvercurrentLevelSel, driverOpenLoadLevelSel;
    wire [5:0] shortCmpPin, overCmpHiPin, overCmpLoPin, openCmpHiPin, openCmpLoPin;
    wire [5:0] driverEnable_r, overcurrentLevel_r, openLoadLevel_r;
    wire [5:0] outputShortFlag_r, driverTripFlag_r, driverOpenLoadFlag_r;
    wire glassSupplyMode_r, supplyAbove20vPin;
    integer err_total, checks_done, n, m, i;

    hsfm_monitor hsfm_monitor_inst (.*);
    hsfm_far_side hsfm_far_side_inst (.*);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function integer dgCyc(input [1:0] sel);
        case (sel)
            `HSFM_DGSEL_48: dgCyc = `HSFM_DG_48_CYC;
            `HSFM_DGSEL_40: dgCyc = `HSFM_DG_40_CYC;
            `HSFM_DGSEL_32: dgCyc = `HSFM_DG_32_CYC;
            default: dgCyc = `HSFM_DG_24_CYC;
        endcase
    endfunction

    function flagOf(input [1:0] kind, input integer b);
        flagOf = kind == 2'h0 ? outputShortFlag_r[b] : kind == 2'h1 ? driverTripFlag_r[b] : driverOpenLoadFlag_r[b];
    endfunction

    task check(input [31:0] seen, input [31:0] exp, input [127:0] what);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("FAIL %0s expected %0h seen %0h", what, exp, seen);
            end
        end
    endtask

    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, err_total);
            if (err_total == 0 && checks_done > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    task wait_flag(input [1:0] kind, input integer b, input integer limit, output integer cyc);
        begin
            cyc = 0;
            while (flagOf(kind, b) !== 1'b1 && cyc < limit) begin
                @(negedge clk);
                cyc = cyc + 1;
            end
            if (cyc >= limit) begin
                err_total = err_total + 1;
                $display("FAIL flag wait expected set seen timeout");
                end_of_test;
            end
        end
    endtask

    task clear_all;
        begin
            repeat (4) @(negedge clk);
            clearFaults = 1'b1;
            @(negedge clk);
            clearFaults = 1'b0;
            @(negedge clk);
        end
    endtask

    initial begin
        err_total = 0;
        checks_done = 0;
        reset = 1'b1;
        {driverOnCmd, driverOpenLoadEnable, shortFault, overFault, openFault} = 30'h0;
        {glassSupplyOn, glassSupplyModeWr, glassSupplyModeVal, clearFaults, hvSupply} = 5'h0;
        {firstDriverDeglitchSel, sharedDriverDeglitchSel, firstDriverRetryEnable, firstDriverResistanceMode} = 6'h0;
        {driverRetryEnable, driverOvercurrentLevelSel, driverOpenLoadLevelSel} = 15'h0;
        n = $urandom(32'h75C75F5F);
        n = $urandom;
        repeat (16) @(negedge clk);
        reset = 1'b0;
        check(glassSupplyMode_r, 1'h1, "glass mode");
        check({outputShortFlag_r, driverTripFlag_r, driverOpenLoadFlag_r}, 18'h0, "reset flags");
        firstDriverResistanceMode = n[0];
        driverOvercurrentLevelSel = n[5:1];
        driverOpenLoadLevelSel = n[10:6];
        sharedDriverDeglitchSel = n[12:11];
        driverRetryEnable = {n[15:13], 2'h2};
        repeat (3) @(negedge clk);
        check(overcurrentLevel_r, {driverOvercurrentLevelSel, firstDriverResistanceMode}, "oc level");
        check(openLoadLevel_r, {driverOpenLoadLevelSel, firstDriverResistanceMode}, "ol level");
        // Fifth driver handed to the glass stage, then released
        driverOnCmd[4] = 1'b1;
        repeat (3) @(negedge clk);
        check(driverEnable_r[4], 1'h0, "glass ignores cmd");
        glassSupplyOn = 1'b1;
        repeat (3) @(negedge clk);
        check(driverEnable_r[4], 1'h1, "glass on");
        {glassSupplyOn, driverOnCmd[4], glassSupplyModeWr} = 3'h1;
        @(negedge clk);
        {driverOnCmd[4], glassSupplyModeWr} = 2'h2;
        repeat (3) @(negedge clk);
        check({glassSupplyMode_r, driverEnable_r[4]}, 2'h1, "own mode");
        driverOnCmd[4] = 1'b0;
        // Short, retried overcurrent and open load side by side at high supply
        hvSupply = 1'b1;
        driverOpenLoadEnable = 6'h08;
        {shortFault, overFault, openFault} = {6'h02, 6'h04, 6'h08};
        driverOnCmd = 6'h0E;
        wait_flag(2'h0, 1, 6000, n);
        m = `HSFM_BLANK_CYC + `HSFM_DG_HV_CYC;
        check(n >= m && n <= m + 12, 1'h1, "short time");
        check(driverEnable_r[1], 1'h0, "short off");
        repeat (1500) @(negedge clk);
        check(driverTripFlag_r[2], 1'h0, "retry no trip");
        wait_flag(2'h2, 3, 30000, n);
        check(driverEnable_r[3], 1'h1, "open stays on");
        clear_all;
        check({outputShortFlag_r, driverTripFlag_r, driverOpenLoadFlag_r, driverEnable_r[1]}, 19'h0, "clear");
        driverOnCmd = 6'h00;
        {shortFault, overFault, openFault, hvSupply} = 19'h0;
        repeat (2) @(negedge clk);
        driverOnCmd[1] = 1'b1;
        repeat (3) @(negedge clk);
        check(driverEnable_r[1], 1'h1, "re-enable");
        driverOnCmd[1] = 1'b0;
        overFault = 6'h01;
        // Every deglitch code on the first driver, low supply
        for (i = 0; i < 4; i = i + 1) begin
            firstDriverDeglitchSel = i[1:0];
            driverOnCmd[0] = 1'b1;
            wait_flag(2'h1, 0, 9000, n);
            m = `HSFM_BLANK_CYC + dgCyc(i[1:0]);
            check(n >= m && n <= m + 12, 1'h1, "trip time");
            check(driverEnable_r[0], 1'h0, "trip off");
            driverOnCmd[0] = 1'b0;
            clear_all;
        end
        end_of_test;
    end
endmodule
